// File: inc/adcsc_pkg.sv
package adcsc_pkg;
  localparam int ADDR_BITS = 4;
  localparam int RESULT_BITS = 10;
  localparam int NUM_EXT_INPUTS = 11;
  localparam int NUM_SOURCES = 14;
  localparam int SAMPLE_START_EDGE = 4;
  localparam int LAST_DATA_EDGE = 9;
  localparam int CONVERT_EDGE = 10;
  localparam int MAX_FRAME_CLOCKS = 16;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 10000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [3:0] ADDR_RESET = 4'h0;
  localparam logic [3:0] TEST_MID = 4'hb;
  localparam logic [3:0] TEST_LOW = 4'hc;
  localparam logic [3:0] TEST_HIGH = 4'hd;

  typedef struct packed {
    logic chipSelN;
    logic serClk;
    logic serAddr;
  } adcsc_link_s;

  typedef struct packed {
    logic sampling;
    logic [3:0] source;
  } adcsc_mux_s;
endpackage : adcsc_pkg

// File: design/adcsc_sync.sv
`timescale 1ns/1ps
module adcsc_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;

  initial begin
    if (WIDTH < 1) $error("adcsc_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1_q <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule : adcsc_sync

// File: design/adcsc_serial_ctrl.sv
`timescale 1ns/1ps
module adcsc_serial_ctrl
  import adcsc_pkg::*;
#(
  parameter int CONV_COUNT = adcsc_pkg::CONV_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire adcsc_pkg::adcsc_link_s linkIn,
  input wire logic [adcsc_pkg::RESULT_BITS-1:0] convValue,
  output logic dataOut,
  output logic dataOutEn,
  output logic convDone,
  output adcsc_pkg::adcsc_mux_s muxSel,
  output logic [adcsc_pkg::RESULT_BITS-1:0] resultWord
);
  import adcsc_pkg::*;

  typedef enum logic [1:0] {IDLE, FRAME, CONVERT} adcsc_state_e;

  initial begin
    if (CONV_COUNT < 1 || CONV_COUNT > 65535) $error("CONV_COUNT out of range");
  end

  adcsc_link_s linkSync;
  adcsc_state_e state_q;
  logic chipSelN_q;
  logic serClk_q;
  logic [4:0] riseCnt_q;
  logic [4:0] fallCnt_q;
  logic [3:0] addr_q;
  logic [9:0] shift_q;
  logic [15:0] convCnt_q;
  logic active;
  logic csFall;
  logic clkRise;
  logic clkFall;
  logic convEnd;
  logic rearm;

  // Sync resets to the pin idle levels so no false serial clock edge follows reset
  adcsc_sync #(.WIDTH(3), .RESET_VAL(3'b100)) uSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .asyncIn(linkIn),
    .syncOut(linkSync)
  );

  // Pins are only enabled while the synchronised select is low
  assign active = !linkSync.chipSelN;
  assign csFall = chipSelN_q && !linkSync.chipSelN;
  assign clkRise = active && !csFall && !serClk_q && linkSync.serClk;
  assign clkFall = active && !csFall && serClk_q && !linkSync.serClk;
  assign convEnd = state_q == CONVERT && convCnt_q == 16'h0;
  // Held select rearms only after 10 or 16 clocks; a longer frame keeps its zero tail
  assign rearm = convEnd && active
    && (fallCnt_q == 5'(CONVERT_EDGE) || fallCnt_q == 5'(MAX_FRAME_CLOCKS));

  function automatic logic isValidSource(input logic [3:0] a);
    return (a < 4'(NUM_EXT_INPUTS)) || a == TEST_MID || a == TEST_LOW || a == TEST_HIGH;
  endfunction : isValidSource

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chipSelN_q <= 1'b1;
      serClk_q <= 1'b0;
    end else begin
      chipSelN_q <= linkSync.chipSelN;
      serClk_q <= linkSync.serClk;
    end
  end

  // Edge counters restart on every select falling edge
  always_ff @(posedge core_clk) begin
    if (!rst_n || csFall || rearm) begin
      riseCnt_q <= '0;
      fallCnt_q <= '0;
    end else begin
      if (clkRise && riseCnt_q != 5'(MAX_FRAME_CLOCKS)) riseCnt_q <= riseCnt_q + 5'h1;
      if (clkFall && fallCnt_q != 5'(MAX_FRAME_CLOCKS)) fallCnt_q <= fallCnt_q + 5'h1;
    end
  end

  // Address shifts only on the first four rising edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_q <= ADDR_RESET;
    end else if (clkRise && riseCnt_q < 5'(ADDR_BITS)) begin
      addr_q <= {addr_q[2:0], linkSync.serAddr};
    end
  end

  // Illegal codes fall back to input zero; the mux never sees an undefined source
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      muxSel <= '0;
    end else begin
      muxSel.source <= isValidSource(addr_q) ? addr_q : 4'h0;
      muxSel.sampling <= active && state_q == FRAME
        && fallCnt_q >= 5'(SAMPLE_START_EDGE) && fallCnt_q < 5'(CONVERT_EDGE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= IDLE;
      convCnt_q <= '0;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (csFall) state_q <= FRAME;
        end
        FRAME: begin
          if (!active) begin
            state_q <= IDLE;
          end else if (clkFall && fallCnt_q == 5'(CONVERT_EDGE - 1)) begin
            state_q <= CONVERT;
            convCnt_q <= 16'(CONV_COUNT - 1);
          end
        end
        CONVERT: begin
          if (convCnt_q == 16'h0) begin
            state_q <= active ? FRAME : IDLE;
          end else begin
            convCnt_q <= convCnt_q - 16'h1;
          end
        end
      endcase
    end
  end

  // Conversion runs to completion even if select rises meanwhile
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      convDone <= 1'b1;
      resultWord <= RESULT_RESET;
    end else if (state_q == FRAME && active && clkFall
                 && fallCnt_q == 5'(CONVERT_EDGE - 1)) begin
      convDone <= 1'b0;
    end else if (state_q == CONVERT && convCnt_q == 16'h0) begin
      convDone <= 1'b1;
      resultWord <= convValue;
    end
  end

  // Shift register reloads on select fall and on a rearm under held select
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shift_q <= RESULT_RESET;
      dataOut <= 1'b0;
      dataOutEn <= 1'b0;
    end else begin
      dataOutEn <= active;
      if (csFall) begin
        shift_q <= resultWord;
        dataOut <= resultWord[RESULT_BITS-1];
      end else if (rearm) begin
        shift_q <= convValue;
        dataOut <= convValue[RESULT_BITS-1];
      end else if (clkFall) begin
        if (fallCnt_q < 5'(LAST_DATA_EDGE)) begin
          shift_q <= {shift_q[8:0], 1'b0};
          dataOut <= shift_q[RESULT_BITS-2];
        end else begin
          dataOut <= 1'b0;
        end
      end
    end
  end

  a_out_tristate: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 dataOutEn == !$past(linkSync.chipSelN))
    else $error("output enable does not follow select");
  a_msb_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    csFall |=> dataOut == $past(resultWord[9]))
    else $error("MSB not presented at frame start");
  a_zero_tail: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkFall && fallCnt_q >= 5'(LAST_DATA_EDGE) && !rearm
    |=> !dataOut)
    else $error("tail bits not zero");
  a_done_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == FRAME && active && clkFall && fallCnt_q == 5'(CONVERT_EDGE - 1)
    |=> !convDone)
    else $error("done flag did not fall at tenth edge");
  a_done_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == CONVERT && convCnt_q != 0 |=> !convDone)
    else $error("done flag rose early");
  a_done_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == CONVERT && convCnt_q == 0 |=> convDone && resultWord == $past(convValue))
    else $error("done flag or result missing at completion");
  a_addr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    riseCnt_q >= 5'd4 && !csFall |=> $stable(addr_q))
    else $error("address changed after capture");
  a_sample_win: assert property (@(posedge core_clk) disable iff (!rst_n)
    muxSel.sampling |-> $past(fallCnt_q) >= 5'd4 && $past(fallCnt_q) < 5'd10)
    else $error("sampling outside window");
  a_mux_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
    muxSel.source < 4'd11 || muxSel.source inside {4'hb, 4'hc, 4'hd})
    else $error("mux source illegal");

  c_frame: cover property (@(posedge core_clk) csFall ##[1:1000] clkFall);
  c_convert: cover property (@(posedge core_clk) state_q == CONVERT ##1 state_q != CONVERT);
  c_long_frame: cover property (@(posedge core_clk) clkFall && fallCnt_q == 5'd12);
endmodule : adcsc_serial_ctrl

// File: test/adcsc_host_model.sv
`timescale 1ns/1ps
module adcsc_host_model (
  input wire logic core_clk,
  input wire logic dataOut,
  input wire logic dataOutEn,
  output adcsc_pkg::adcsc_link_s linkOut
);
  import adcsc_pkg::*;
  logic [9:0] rxWord;
  logic tailZero;
  logic enHeld;
  initial begin
    linkOut = 3'b100;
  end
  task automatic wait_neg(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_neg
  // Serial clock idles low; 400 ns period keeps edges 4 core clocks apart
  task automatic frame(input logic [3:0] addr, input int nClk);
    rxWord = 10'h000;
    tailZero = 1'b1;
    enHeld = 1'b1;
    @(negedge core_clk);
    linkOut.chipSelN = 1'b0;
    wait_neg(8);
    for (int i = 0; i < nClk; i++) begin
      // Past the address the line keeps toggling, so a late capture shows
      linkOut.serAddr = (i < 4) ? addr[3 - i] : ~linkOut.serAddr;
      wait_neg(2);
      linkOut.serClk = 1'b1;
      wait_neg(4);
      enHeld = enHeld & dataOutEn;
      if (i < 10) rxWord[9 - i] = dataOut;
      else tailZero = tailZero & ~dataOut;
      linkOut.serClk = 1'b0;
      wait_neg(2);
    end
    linkOut.chipSelN = 1'b1;
    linkOut.serAddr = ~linkOut.serAddr;
  endtask : frame
  // Clock and address activity with select high must leave the device untouched
  task automatic stray(input int nClk);
    for (int i = 0; i < nClk; i++) begin
      linkOut.serAddr = ~linkOut.serAddr;
      wait_neg(2);
      linkOut.serClk = 1'b1;
      wait_neg(4);
      linkOut.serClk = 1'b0;
      wait_neg(2);
    end
  endtask : stray
endmodule : adcsc_host_model

// File: test/test_adc_serial_control_interface.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin checks++; if ((got) !== (exp)) begin errorCnt++; \
  $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end
module test_adc_serial_control_interface;
  import adcsc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  adcsc_link_s linkIn;
  logic [9:0] convValue = 10'h000;
  logic dataOut, dataOutEn, convDone;
  adcsc_mux_s muxSel;
  logic [9:0] resultWord;
  logic [9:0] prevWord = 10'h000;
  int errorCnt = 0;
  int checks = 0;
  int cycles = 0;
  int sampleCnt = 0;
  // Host clock period is eight core clocks, so the six-clock window spans 48 of them
  localparam int SAMPLE_CYCLES = (CONVERT_EDGE - SAMPLE_START_EDGE) * 8;
  // Short conversion keeps the run brief
  adcsc_serial_ctrl #(.CONV_COUNT(10)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .linkIn(linkIn), .convValue(convValue), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .convDone(convDone), .muxSel(muxSel), .resultWord(resultWord));
  adcsc_host_model host_u (.core_clk(core_clk), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .linkOut(linkIn));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      errorCnt++;
      report_and_stop();
    end
  end
  always @(posedge core_clk) begin
    if (muxSel.sampling === 1'b1) sampleCnt <= sampleCnt + 1;
  end
  task automatic do_frame(input logic [3:0] addr, input int nClk, input logic [9:0] val);
    @(negedge core_clk);
    convValue = val;
    sampleCnt = 0;
    host_u.frame(addr, nClk);
    host_u.wait_neg(4);
    if (nClk == 10) `CHK("convDone low", 1'b0, convDone)
    `CHK("sampling cycles", SAMPLE_CYCLES, sampleCnt)
    for (int k = 0; k < 60 && convDone !== 1'b1; k++) @(negedge core_clk);
    `CHK("convDone high", 1'b1, convDone)
    `CHK("result serial", prevWord, host_u.rxWord)
    `CHK("tail zeros", 1'b1, host_u.tailZero)
    `CHK("enable in frame", 1'b1, host_u.enHeld)
    `CHK("source", (addr > 4'hd) ? 4'h0 : addr, muxSel.source)
    `CHK("result word", val, resultWord)
    host_u.wait_neg(6);
    `CHK("enable off", 1'b0, dataOutEn)
    prevWord = val;
  endtask : do_frame
  task automatic test_reset();
    `CHK("reset enable", 1'b0, dataOutEn)
    `CHK("reset done", 1'b1, convDone)
    `CHK("reset result", 10'h000, resultWord)
    `CHK("reset source", 4'h0, muxSel.source)
    host_u.stray(6);
    host_u.wait_neg(4);
    `CHK("stray source", 4'h0, muxSel.source)
    `CHK("stray no enable", 1'b0, dataOutEn)
    `CHK("stray done", 1'b1, convDone)
    $display("test_reset done");
  endtask : test_reset
  task automatic test_codes();
    logic [3:0] codes [7] = '{4'h5, 4'hb, 4'hc, 4'hd, 4'ha, 4'he, 4'h0};
    for (int i = 0; i < 7; i++) do_frame(codes[i], 10, 10'(10'h2c3 ^ (10'h041 * i)));
    $display("test_codes done");
  endtask : test_codes
  task automatic test_long();
    do_frame(4'h7, 16, 10'h2a5);
    do_frame(4'h1, 12, 10'h35a);
    $display("test_long done");
  endtask : test_long
  task automatic test_abort();
    host_u.frame(4'h3, 5);
    host_u.wait_neg(20);
    `CHK("abort head", prevWord[9:5], host_u.rxWord[9:5])
    `CHK("abort no conv", 1'b1, convDone)
    `CHK("abort source", 4'h3, muxSel.source)
    do_frame(4'h9, 10, 10'h1ff);
    $display("test_abort done");
  endtask : test_abort
  initial begin
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    test_reset();
    test_codes();
    test_long();
    test_abort();
    report_and_stop();
  end
endmodule : test_adc_serial_control_interface
